// [core/wfx_top.sv]
`timescale 1ns/1ps
module wfx_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer and system side, same clock except debug break
    input wire logic [7:0] event_ch,
    input wire logic debug_break,
    input wire logic timer_update,
    input wire logic timer_update_lock,
    input wire logic [3:0] cc_wave,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_dir,
    // pin side
    output logic [7:0] pin_out,
    output logic [7:0] pin_dir,
    output logic fault_active
);
    // register state
    wfx_pkg::wfx_ctrl_s ctrl_r;
    logic lock_r;
    logic [7:0] fault_channel_mask_r;
    logic debug_break_ignore_r;
    logic restart_mode_select_r;
    wfx_pkg::wfx_action_e fault_action_select_r;
    logic fault_seen_flag_r;
    logic high_buffer_valid_r;
    logic low_buffer_valid_r;
    wfx_pkg::wfx_deadtime_s active_r;
    wfx_pkg::wfx_deadtime_s buffer_r;
    logic [7:0] output_override_enable_r;
    logic [7:0] dir_clear_r;
    wfx_pkg::wfx_state_e state_r;
    logic dbg_sync;
    logic [7:0] dt_pins;
    logic [7:0] ovr_restore;
    logic [7:0] dir_restore;
    logic [3:0] dt_wave;

    // apb decode
    logic [3:0] idx;
    logic wr_en;
    logic mapped;
    logic addr_ok;
    logic idx_hole;
    logic protect_on;
    logic fault_cond;
    logic fault_event;
    logic clear_flag;
    logic do_update;
    logic [7:0] wbyte;
    logic [7:0] rd_nxt;

    assign idx = paddr[wfx_pkg::ADDR_MSB:wfx_pkg::ADDR_LSB];
    assign wbyte = pwdata[7:0];
    // writes land only at the edge that completes the access phase, never twice
    assign wr_en = psel && penable && pwrite && pready && ce;
    // misaligned, out-of-range and hole addresses answer with an error and read zero
    assign addr_ok = (paddr[31:wfx_pkg::ADDR_MSB+1] == 26'h0) && (paddr[1:0] == 2'b00);
    assign idx_hole = (idx == 4'h1) || (idx == 4'h5) || (idx == 4'he) || (idx == 4'hf);
    assign mapped = addr_ok && !idx_hole;

    // debug break arrives from another domain; resynchronise it first
    wfx_sync #(.W(1)) u_dbg_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .d(debug_break),
        .q(dbg_sync)
    );

    // action 00 and reserved 10 disable protection
    assign protect_on = (fault_action_select_r == wfx_pkg::WFX_ACT_CLEAR_OVR) ||
                        (fault_action_select_r == wfx_pkg::WFX_ACT_CLEAR_DIR);
    // fault condition: OR of enabled channels plus debug break
    assign fault_cond = protect_on && ((|(event_ch & fault_channel_mask_r)) ||
                        (dbg_sync && !debug_break_ignore_r));
    // events are levels: the flag re-arms every cycle they stay high, so a clear meanwhile is lost
    assign fault_event = fault_cond;
    assign clear_flag = wr_en && mapped && idx == wfx_pkg::IDX_STATUS && wbyte[wfx_pkg::STAT_FAULT_BIT];
    assign do_update = timer_update && !timer_update_lock;

    // control, lock and mask; lock freezes control and mask
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= '0;
            lock_r <= 1'b0;
            fault_channel_mask_r <= wfx_pkg::ZERO8;
        end else if (wr_en && mapped) begin
            if (idx == wfx_pkg::IDX_LOCK) begin
                lock_r <= lock_r | wbyte[0]; // sticky until reset, as a lock should be
            end
            if (!lock_r && idx == wfx_pkg::IDX_CTRL) begin
                ctrl_r <= wbyte[5:0] & wfx_pkg::CTRL_MASK[5:0];
            end
            if (!lock_r && idx == wfx_pkg::IDX_FMASK) begin
                fault_channel_mask_r <= wbyte;
            end
        end
    end

    // fault control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            debug_break_ignore_r <= 1'b0;
            restart_mode_select_r <= 1'b0;
            fault_action_select_r <= wfx_pkg::WFX_ACT_NONE;
        end else if (wr_en && mapped && idx == wfx_pkg::IDX_FCTRL) begin
            debug_break_ignore_r <= wbyte[wfx_pkg::FCTRL_DBG_IGNORE_BIT];
            restart_mode_select_r <= wbyte[wfx_pkg::FCTRL_MODE_BIT];
            fault_action_select_r <= wfx_pkg::wfx_action_e'(wbyte[1:0]);
        end
    end

    // fault flag: set wins over software clear, zero writes ignored
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_seen_flag_r <= 1'b0;
        end else if (ce) begin
            if (fault_event) begin
                fault_seen_flag_r <= 1'b1;
            end else if (clear_flag) begin
                fault_seen_flag_r <= 1'b0;
            end
        end
    end

    // fault state machine; exit waits for the timer update
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= wfx_pkg::WFX_ST_RUN;
        end else if (ce) begin
            unique case (state_r)
                wfx_pkg::WFX_ST_RUN: begin
                    if (fault_event) begin
                        state_r <= wfx_pkg::WFX_ST_FAULT;
                    end
                end
                wfx_pkg::WFX_ST_FAULT: begin
                    if (timer_update && !fault_cond) begin
                        if (restart_mode_select_r) begin
                            state_r <= wfx_pkg::WFX_ST_RUN;
                        end else if (!fault_seen_flag_r) begin
                            state_r <= wfx_pkg::WFX_ST_RUN;
                        end
                    end
                end
                default: state_r <= wfx_pkg::WFX_ST_FAULT;
            endcase
        end
    end

    // restore values: pattern uses low buffer, else pin pairs of enabled channels
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pairs
            assign dt_pins[2*g] = ctrl_r.dt_ch_en[g];
            assign dt_pins[2*g+1] = ctrl_r.dt_ch_en[g];
            assign dt_wave[g] = ctrl_r.cwcm ? cc_wave[0] : cc_wave[g];
        end
    endgenerate
    assign ovr_restore = ctrl_r.pattern_mode_enable ? buffer_r.low : dt_pins;
    assign dir_restore = ctrl_r.pattern_mode_enable ? buffer_r.low : dt_pins;

    // override enable: write gated by flag and lock, cleared by fault, reloaded at update
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            output_override_enable_r <= wfx_pkg::ZERO8;
        end else if (ce) begin
            if (fault_event && fault_action_select_r == wfx_pkg::WFX_ACT_CLEAR_OVR) begin
                output_override_enable_r <= wfx_pkg::ZERO8;
            end else if (state_r == wfx_pkg::WFX_ST_FAULT && timer_update && !fault_cond &&
                         (restart_mode_select_r || !fault_seen_flag_r) &&
                         fault_action_select_r == wfx_pkg::WFX_ACT_CLEAR_OVR) begin
                output_override_enable_r <= ovr_restore;
            end else if (wr_en && mapped && idx == wfx_pkg::IDX_OVR_EN && !fault_seen_flag_r && !lock_r) begin
                output_override_enable_r <= wbyte;
            end
        end
    end

    // direction clear mask: set on fault, released on exit from fault state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dir_clear_r <= wfx_pkg::ZERO8;
        end else if (ce) begin
            if (fault_event && fault_action_select_r == wfx_pkg::WFX_ACT_CLEAR_DIR) begin
                dir_clear_r <= dir_restore;
            end else if (state_r == wfx_pkg::WFX_ST_RUN) begin
                dir_clear_r <= wfx_pkg::ZERO8;
            end
        end
    end

    // dead-time active and buffer registers with valid flags
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            active_r <= '0;
            buffer_r <= '0;
            high_buffer_valid_r <= 1'b0;
            low_buffer_valid_r <= 1'b0;
        end else if (ce) begin
            if (do_update) begin
                if (low_buffer_valid_r) begin
                    active_r.low <= buffer_r.low;
                    low_buffer_valid_r <= 1'b0;
                end
                if (high_buffer_valid_r) begin
                    active_r.high <= buffer_r.high;
                    high_buffer_valid_r <= 1'b0;
                end
            end
            if (wr_en && mapped) begin
                unique case (idx)
                    wfx_pkg::IDX_DT_BOTH: active_r <= '{low: wbyte, high: wbyte};
                    wfx_pkg::IDX_DT_LOW: active_r.low <= wbyte;
                    wfx_pkg::IDX_DT_HIGH: active_r.high <= wbyte;
                    wfx_pkg::IDX_DT_BOTH_BUF: begin
                        buffer_r <= '{low: wbyte, high: wbyte};
                        low_buffer_valid_r <= 1'b1;
                        high_buffer_valid_r <= 1'b1;
                    end
                    wfx_pkg::IDX_DT_LOW_BUF: begin
                        buffer_r.low <= wbyte;
                        low_buffer_valid_r <= 1'b1;
                    end
                    wfx_pkg::IDX_DT_HIGH_BUF: begin
                        buffer_r.high <= wbyte;
                        high_buffer_valid_r <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // four dead-time generators, one per compare channel
    logic [3:0] ls_w;
    logic [3:0] hs_w;
    generate
        for (g = 0; g < 4; g++) begin : g_dti
            wfx_dtgen u_dt (
                .ref_clk(ref_clk),
                .rst(rst),
                .ce(ce),
                .en(ctrl_r.dt_ch_en[g]),
                .wave(dt_wave[g]),
                .dt_low(active_r.low),
                .dt_high(active_r.high),
                .low_side(ls_w[g]),
                .high_side(hs_w[g])
            );
        end
    endgenerate

    // pin mux: override replaces output only; direction just gets fault clear
    logic [7:0] ovr_src;
    always_comb begin
        ovr_src = {hs_w[3], ls_w[3], hs_w[2], ls_w[2], hs_w[1], ls_w[1], hs_w[0], ls_w[0]};
        if (ctrl_r.pattern_mode_enable) begin
            ovr_src = {8{cc_wave[0]}}; // pattern: channel a waveform on every overridden pin
        end
    end

    // registered pins so nothing combinational reaches the port
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_out <= wfx_pkg::ZERO8;
            pin_dir <= wfx_pkg::ZERO8;
            fault_active <= 1'b0;
        end else if (ce) begin
            pin_out <= (ovr_src & output_override_enable_r) | (port_out & ~output_override_enable_r);
            pin_dir <= port_dir & ~dir_clear_r;
            fault_active <= state_r == wfx_pkg::WFX_ST_FAULT;
        end
    end

    // read mux; status upper bits are zero
    always_comb begin
        rd_nxt = wfx_pkg::ZERO8;
        unique case (idx)
            wfx_pkg::IDX_CTRL: rd_nxt = {2'b00, ctrl_r};
            wfx_pkg::IDX_FMASK: rd_nxt = fault_channel_mask_r;
            wfx_pkg::IDX_FCTRL: rd_nxt = {3'b000, debug_break_ignore_r, 1'b0, restart_mode_select_r,
                                          fault_action_select_r};
            wfx_pkg::IDX_STATUS: rd_nxt = {5'b00000, fault_seen_flag_r, high_buffer_valid_r,
                                           low_buffer_valid_r};
            wfx_pkg::IDX_DT_LOW: rd_nxt = active_r.low;
            wfx_pkg::IDX_DT_HIGH: rd_nxt = active_r.high;
            wfx_pkg::IDX_DT_LOW_BUF: rd_nxt = buffer_r.low;
            wfx_pkg::IDX_DT_HIGH_BUF: rd_nxt = buffer_r.high;
            wfx_pkg::IDX_OVR_EN: rd_nxt = output_override_enable_r;
            wfx_pkg::IDX_LOCK: rd_nxt = {7'h00, lock_r};
            default: rd_nxt = wfx_pkg::ZERO8;
        endcase
    end

    // apb answer: no wait state, ready pulses in the first access cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite && mapped) ? {24'h0, rd_nxt} : 32'h0;
        end
    end
endmodule : wfx_top

// [core/wfx_pkg.sv]
package wfx_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_FMASK = 4'h2;
    localparam logic [3:0] IDX_FCTRL = 4'h3;
    localparam logic [3:0] IDX_STATUS = 4'h4;
    localparam logic [3:0] IDX_DT_BOTH = 4'h6;
    localparam logic [3:0] IDX_DT_BOTH_BUF = 4'h7;
    localparam logic [3:0] IDX_DT_LOW = 4'h8;
    localparam logic [3:0] IDX_DT_HIGH = 4'h9;
    localparam logic [3:0] IDX_DT_LOW_BUF = 4'ha;
    localparam logic [3:0] IDX_DT_HIGH_BUF = 4'hb;
    localparam logic [3:0] IDX_OVR_EN = 4'hc;
    localparam logic [3:0] IDX_LOCK = 4'hd;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 5;

    // field positions
    localparam int CTRL_PGM_BIT = 5;
    localparam int CTRL_CWCM_BIT = 4;
    localparam int FCTRL_DBG_IGNORE_BIT = 4;
    localparam int FCTRL_MODE_BIT = 2;
    localparam int STAT_FAULT_BIT = 2;
    localparam int STAT_HIGH_VALID_BIT = 1;
    localparam int STAT_LOW_VALID_BIT = 0;

    // writable masks; reserved bits hold zero
    localparam logic [7:0] CTRL_MASK = 8'h3f;
    localparam logic [7:0] FCTRL_MASK = 8'h17;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [3:0] ZERO4 = 4'h0;

    typedef enum logic [1:0] {
        WFX_ACT_NONE = 2'b00,
        WFX_ACT_CLEAR_OVR = 2'b01,
        WFX_ACT_RSVD = 2'b10,
        WFX_ACT_CLEAR_DIR = 2'b11
    } wfx_action_e;

    typedef enum logic [1:0] {
        WFX_ST_RUN = 2'b01,
        WFX_ST_FAULT = 2'b10
    } wfx_state_e;

    typedef struct packed {
        logic pattern_mode_enable;
        logic cwcm;
        logic [3:0] dt_ch_en;
    } wfx_ctrl_s;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
    } wfx_deadtime_s;
endpackage : wfx_pkg

// [core/wfx_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser for pin-side levels
module wfx_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : wfx_sync

// [core/wfx_dtgen.sv]
`timescale 1ns/1ps
// one dead-time generator: counts off time after each waveform edge
module wfx_dtgen (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic en,
    input wire logic wave,
    input wire logic [7:0] dt_low,
    input wire logic [7:0] dt_high,
    output logic low_side,
    output logic high_side
);
    logic wave_d_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    // rising edge loads low-side count, falling edge high-side count
    always_comb begin
        cnt_nxt = cnt_r;
        if (wave && !wave_d_r) begin
            cnt_nxt = dt_low;
        end else if (!wave && wave_d_r) begin
            cnt_nxt = dt_high;
        end else if (cnt_r != wfx_pkg::ZERO8) begin
            cnt_nxt = cnt_r - 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wave_d_r <= 1'b0;
            cnt_r <= 8'h00;
            low_side <= 1'b0;
            high_side <= 1'b0;
        end else if (ce) begin
            wave_d_r <= wave;
            cnt_r <= cnt_nxt;
            // both sides off while the counter runs; bypass when disabled
            low_side <= en ? (wave && cnt_nxt == wfx_pkg::ZERO8) : wave;
            high_side <= en ? (!wave && cnt_nxt == wfx_pkg::ZERO8) : 1'b0;
        end
    end
endmodule : wfx_dtgen

// [tb/wfx_monitor.sv]
`timescale 1ns/1ps
// port-level checks for bus answers and fault timing
module wfx_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] event_ch,
    input wire logic debug_break,
    input wire logic timer_update,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] pin_dir,
    input wire logic fault_active
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // bus answer: one wait-free access cycle, data only while answering
    a_ready_next: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready && psel && penable) else $error("error outside answer");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    a_stat_zero: assert property (pready && !pwrite && paddr == 32'h10 |-> prdata[7:3] == 5'h0)
        else $error("status upper bits set");
    // fault entry needs a recent event or a synchronised break; the break path is slower
    a_fault_cause: assert property ($rose(fault_active) |-> (|$past(event_ch)) || (|$past(event_ch, 2))
        || $past(debug_break, 3) || $past(debug_break, 4) || $past(debug_break, 5)) else $error("fault without cause");
    // leaving fault only happens at an update
    a_exit_upd: assert property ($fell(fault_active) |-> $past(timer_update) || $past(timer_update, 2))
        else $error("fault left without update");
    a_hold_fault: assert property (fault_active && !timer_update && !$past(timer_update) |=> fault_active)
        else $error("fault dropped early");
    // direction is only ever cleared, never set, and passes through outside fault
    a_dir_sub: assert property ((pin_dir & ~$past(port_dir)) == 8'h0)
        else $error("direction bit raised");
    a_dir_pass: assert property (!fault_active && !$past(fault_active) && !$past(fault_active, 2) && !$past(rst)
        |-> pin_dir == $past(port_dir)) else $error("direction not passed");

    c_fault: cover property ($rose(fault_active));
    c_exit: cover property ($fell(fault_active));
    c_err: cover property (pslverr);
    c_wr: cover property (pready && pwrite);
endmodule : wfx_monitor

bind wfx_top wfx_monitor wfx_monitor_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .event_ch, .debug_break, .timer_update, .port_dir, .pin_dir, .fault_active);

// [tb/wfx_partner.sv]
`timescale 1ns/1ps
// timer side: update pulses while asked, lock level, free compare waves
module wfx_partner (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic lock_req,
    output logic timer_update,
    output logic timer_update_lock,
    output logic [3:0] cc_wave
);
    logic [3:0] cnt_r;
    logic [5:0] wave_r;

    // counter keeps its phase between requests, so answers come fast or slow
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= 4'h0;
            timer_update <= 1'b0;
            timer_update_lock <= 1'b0;
            wave_r <= 6'h0;
        end else begin
            cnt_r <= run ? cnt_r + 4'h1 : cnt_r;
            timer_update <= run && (cnt_r == 4'hf);
            timer_update_lock <= lock_req;
            wave_r <= wave_r + 6'h1;
        end
    end
    assign cc_wave = wave_r[5:2];
endmodule : wfx_partner

// [tb/wfx_top_bench.sv]
`timescale 1ns/1ps
// register model bench; expectations come from the model in rg
module wfx_top_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, debug_break = 1'b0, run = 1'b0, hold_lock = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, seed = 32'h00004c6c;
    logic [7:0] event_ch = 8'h0, port_out = 8'h0, port_dir = 8'h0, pin_out, pin_dir, m, v;
    logic pready, pslverr, timer_update, timer_update_lock, fault_active;
    logic [3:0] cc_wave;
    logic [7:0] rg [16];
    logic [3:0] rw [9] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
    int mismatches = 0, checked = 0, cyc = 0;

    wfx_top wfx_top_i (.ref_clk, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .event_ch, .debug_break, .timer_update, .timer_update_lock, .cc_wave, .port_out, .port_dir,
        .pin_out, .pin_dir, .fault_active);
    wfx_partner wfx_partner_i (.ref_clk, .rst, .run, .lock_req(hold_lock), .timer_update, .timer_update_lock,
        .cc_wave);

    // 40 MHz clock and a hang limit
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    task automatic summarize();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    // one bus transfer; request held until ready is seen at an edge
    task automatic apb(input logic [3:0] i, input logic w, input logic [7:0] wd, output logic [31:0] d,
        output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {26'h0, i, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // write and mirror it in the model; lock and fault flag gate some registers
    task automatic wr(input logic [3:0] i, input logic [7:0] x);
        logic [31:0] d;
        logic e;
        apb(i, 1'b1, x, d, e);
        case (i)
            4'h0: if (!rg[13][0]) rg[0] = x & 8'h3f;
            4'h2: if (!rg[13][0]) rg[2] = x;
            4'h3: rg[3] = x & 8'h17;
            4'h4: if (x[2]) rg[4][2] = 1'b0;
            4'h6: rg[8] = x;
            4'h7: rg[4][1:0] = 2'h3;
            4'h8, 4'h9: rg[i] = x;
            4'ha: rg[4][0] = 1'b1;
            4'hb: rg[4][1] = 1'b1;
            4'hc: if (!rg[13][0] && !rg[4][2]) rg[12] = x;
            4'hd: rg[13][0] = rg[13][0] | x[0];
            default: ;
        endcase
        if (i == 4'h6)
            rg[9] = x;
        if (i == 4'h7 || i == 4'ha)
            rg[10] = x;
        if (i == 4'h7 || i == 4'hb)
            rg[11] = x;
    endtask : wr

    task automatic rd(input logic [3:0] i);
        logic [31:0] d;
        logic e;
        apb(i, 1'b0, 8'h0, d, e);
        cmp({31'h0, e}, {31'h0, i inside {4'h1, 4'h5, 4'he, 4'hf}});
        cmp(d, {24'h0, rg[i]});
    endtask : rd

    // ask the timer for one update and apply the buffer copy to the model
    task automatic upd();
        int n;
        n = 0;
        run <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (timer_update !== 1'b1 && n < 40);
        if (n >= 40)
            mismatches++;
        run <= 1'b0;
        if (!hold_lock) begin
            if (rg[4][0]) rg[8] = rg[10];
            if (rg[4][1]) rg[9] = rg[11];
            rg[4][1:0] = 2'h0;
        end
        @(posedge ref_clk);
    endtask : upd

    // main sequence
    initial begin
        for (int k = 0; k < 16; k++)
            rg[k] = 8'h0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        port_out <= rnd();
        port_dir <= rnd() | 8'h03;
        for (int k = 0; k < 16; k++)
            if (!(k inside {6, 7, 13})) rd(k[3:0]);
        for (int k = 0; k < 9; k++) begin
            wr(rw[k], rnd());
            rd(rw[k]);
        end
        wr(4'h0, 8'h00);
        wr(4'hc, 8'h00);
        tick(3);
        cmp({24'h0, pin_out}, {24'h0, port_out});
        wr(4'hc, 8'haa);
        tick(3);
        cmp({24'h0, pin_out & 8'h55}, {24'h0, port_out & 8'h55});
        wr(4'hc, 8'h00);
        // double-buffered dead time, with the update lock held and released
        upd();
        rd(4'h8);
        hold_lock <= 1'b1;
        wr(4'h7, rnd());
        rd(4'h4);
        rd(4'ha);
        rd(4'hb);
        upd();
        rd(4'h8);
        rd(4'h4);
        hold_lock <= 1'b0;
        upd();
        rd(4'h8);
        rd(4'h9);
        rd(4'h4);
        wr(4'h6, rnd());
        rd(4'h8);
        rd(4'h9);
        wr(4'ha, rnd());
        upd();
        rd(4'h8);
        rd(4'h9);
        // latched fault clearing the overrides
        wr(4'h3, 8'h01);
        v = rnd();
        m = 8'h01 << v[2:0];
        wr(4'h2, m);
        wr(4'hc, rnd());
        event_ch <= ~m;
        tick(4);
        cmp({31'h0, fault_active}, 32'h0);
        event_ch <= m;
        tick(3);
        cmp({31'h0, fault_active}, 32'h1);
        rg[4][2] = 1'b1;
        rg[12] = 8'h0;
        rd(4'h4);
        rd(4'hc);
        wr(4'hc, 8'hff);
        rd(4'hc);
        wr(4'h4, 8'h00);
        rd(4'h4);
        event_ch <= 8'h0;
        upd();
        cmp({31'h0, fault_active}, 32'h1);
        wr(4'h0, 8'h20);
        wr(4'h4, 8'h04);
        upd();
        tick(1);
        cmp({31'h0, fault_active}, 32'h0);
        rg[12] = rg[10];
        rd(4'hc);
        // cycle-by-cycle fault clearing directions of channel a pins
        wr(4'h0, 8'h01);
        wr(4'h3, 8'h07);
        event_ch <= m;
        tick(3);
        cmp({24'h0, pin_dir}, {24'h0, port_dir & 8'hfc});
        rg[4][2] = 1'b1;
        upd();
        cmp({31'h0, fault_active}, 32'h1);
        event_ch <= 8'h0;
        upd();
        tick(2);
        cmp({31'h0, fault_active}, 32'h0);
        cmp({24'h0, pin_dir}, {24'h0, port_dir});
        rd(4'h4);
        wr(4'h4, 8'h04);
        wr(4'h0, 8'h00);
        // codes 00 and 10 take no action
        for (int k = 0; k < 4; k += 2) begin
            wr(4'h3, k[7:0]);
            event_ch <= m;
            tick(4);
            cmp({31'h0, fault_active}, 32'h0);
            rd(4'h4);
            event_ch <= 8'h0;
        end
        // debug break as a fault source, then ignored
        wr(4'h3, 8'h01);
        debug_break <= 1'b1;
        tick(6);
        cmp({31'h0, fault_active}, 32'h1);
        rg[4][2] = 1'b1;
        rg[12] = 8'h0;
        debug_break <= 1'b0;
        tick(4);
        wr(4'h4, 8'h04);
        upd();
        tick(1);
        cmp({31'h0, fault_active}, 32'h0);
        wr(4'h3, 8'h11);
        debug_break <= 1'b1;
        tick(6);
        cmp({31'h0, fault_active}, 32'h0);
        debug_break <= 1'b0;
        // lock blocks control, mask and override writes
        wr(4'hd, 8'h01);
        wr(4'h0, rnd());
        wr(4'h2, rnd());
        wr(4'hc, rnd());
        rd(4'h0);
        rd(4'h2);
        rd(4'hc);
        rd(4'hd);
        summarize();
    end
endmodule : wfx_top_bench
